// file: kprf_port_core.sv
`timescale 1ns/1ps
module kprf_port_core #(
   parameter int SCAN_WIDTH = 8,
   parameter int KEY_WIDTH = 4
) (
   input wire logic clock,
   input wire logic rstn,
   // CPU port register access
   input wire logic port_wr,
   input wire logic port_rd,
   input wire logic [2:0] port_sel,
   input wire logic [7:0] port_wdata,
   output logic [7:0] port_rdata,
   output logic port_rvalid,
   // Flag instructions
   input wire logic status_test_exec,
   input wire logic halt_exec,
   input wire logic [3:0] cond_operand,
   input wire logic standby_exit,
   input wire logic timer_zero,
   output logic cond_flag,
   output logic standby_enter,
   // Carry instructions
   input wire logic alu_valid,
   input wire kprf_pkg::kprf_alu_op_t alu_op,
   input wire logic [3:0] alu_acc,
   input wire logic [3:0] alu_opnd,
   output logic carry_flag,
   // Control register 0 fields for timer and carrier logic
   output logic [7:0] carrier_ctrl,
   // Key scan pins
   input wire logic [SCAN_WIDTH-1:0] key_scan_in,
   output logic [SCAN_WIDTH-1:0] key_scan_out,
   output logic [SCAN_WIDTH-1:0] key_scan_oe,
   output logic key_scan_pd_en,
   // Key input pins
   input wire logic [KEY_WIDTH-1:0] key_input_pins,
   output logic key_input_pd_en,
   // Sense pins
   input wire logic first_sense_pin,
   output logic first_sense_pd_en,
   output logic first_sense_in_en,
   input wire logic sense_ind_in,
   input wire logic indicator_level_n,
   output logic sense_ind_out,
   output logic sense_ind_oe,
   output logic sense_ind_pd_en
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   localparam int PIN_W = SCAN_WIDTH + KEY_WIDTH + 2;

   typedef struct packed {
      logic [SCAN_WIDTH-1:0] scan_latch;
      logic [7:0] ctrl0;
      logic [7:0] ctrl1;
      logic cond_flag;
      logic standby_enter;
      logic [7:0] rdata;
      logic rvalid;
      logic [SCAN_WIDTH-1:0] scan_out;
      logic [SCAN_WIDTH-1:0] scan_oe;
      logic scan_pd;
      logic key_pd;
      logic s0_pd;
      logic s0_in_en;
      logic s1_out;
      logic s1_oe;
      logic s1_pd;
   } kprf_core_t;

   kprf_core_t st_r;
   kprf_core_t st_nxt;

   logic [PIN_W-1:0] pin_level;
   logic [SCAN_WIDTH-1:0] scan_lvl;
   logic [KEY_WIDTH-1:0] key_lvl;
   logic s0_lvl;
   logic s1_lvl;
   logic s0_read;
   logic cond_now;

   kprf_alu_if alu_bus ();

   // ---------------------------------------------------------------
   // Pin synchronisers and carry unit
   // ---------------------------------------------------------------
   kprf_pin_sync #(
      .WIDTH(PIN_W)
   ) u_sync (
      .clock(clock),
      .rstn(rstn),
      .pin_in({key_scan_in, key_input_pins, first_sense_pin, sense_ind_in}),
      .level(pin_level)
   );

   assign scan_lvl = pin_level[PIN_W-1 -: SCAN_WIDTH];
   assign key_lvl = pin_level[KEY_WIDTH+1 -: KEY_WIDTH];
   assign s0_lvl = pin_level[1];
   assign s1_lvl = pin_level[0];

   // Instruction fields go straight through; the unit holds the flag
   assign alu_bus.op_valid = alu_valid;
   assign alu_bus.op = alu_op;
   assign alu_bus.acc = alu_acc;
   assign alu_bus.opnd = alu_opnd;

   kprf_carry_unit u_carry (
      .clock(clock),
      .rstn(rstn),
      .alu(alu_bus.unit)
   );

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Condition selected by a status test or halt operand
   function automatic logic cond_eval(
      input logic [3:0] opnd,
      input logic key_any,
      input logic tzero,
      input logic sense_any
   );
      logic hit;
      hit = 1'b0;
      case (opnd[2:0])
         kprf_pkg::COND_KEY_A,
         kprf_pkg::COND_KEY_B,
         kprf_pkg::COND_KEY_C: begin
            hit = key_any;
         end
         kprf_pkg::COND_TIMER_ZERO: begin
            hit = tzero;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      if (opnd[kprf_pkg::COND_SENSE_BIT]) begin
         hit = hit | sense_any;
      end
      return hit;
   endfunction : cond_eval

   // Sense0 is disconnected in off mode and reads as one
   assign s0_read = st_r.ctrl1[kprf_pkg::SENSE0_MODE_BIT] ? s0_lvl :
      1'b1;

   // An off sense0 has its input buffer cut, so it cannot match
   assign cond_now = cond_eval(cond_operand, |key_lvl, timer_zero,
      (s0_lvl & st_r.ctrl1[kprf_pkg::SENSE0_MODE_BIT]) | s1_lvl);

   // Read data for a given selection code
   function automatic logic [7:0] port_read(
      input logic [2:0] sel,
      input kprf_core_t s,
      input logic [SCAN_WIDTH-1:0] scan_pins,
      input logic [KEY_WIDTH-1:0] keys,
      input logic s1,
      input logic s0
   );
      logic [7:0] val;
      val = 8'h00;
      case (sel)
         kprf_pkg::SEL_KEY_SCAN: begin
            val = s.ctrl1[kprf_pkg::KEY_SCAN_DIR_BIT] ?
               8'(s.scan_latch) : 8'(scan_pins);
         end
         kprf_pkg::SEL_KEY_INPUT: begin
            val = {keys, s1, s0, kprf_pkg::INPUT_CONST_ONES};
         end
         kprf_pkg::SEL_CARRIER_CTRL: begin
            val = s.ctrl0;
         end
         kprf_pkg::SEL_PIN_MODE: begin
            val = s.ctrl1;
         end
         default: begin
            val = 8'h00;
         end
      endcase
      return val;
   endfunction : port_read

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.standby_enter = 1'b0;
      st_nxt.rvalid = 1'b0;

      // Register reads answer one cycle later from a flop
      if (port_rd) begin
         st_nxt.rdata = port_read(port_sel, st_r, scan_lvl, key_lvl,
            s1_lvl, s0_read);
         st_nxt.rvalid = 1'b1;
      end

      // Register writes; input port selection falls to default
      if (port_wr) begin
         case (port_sel)
            kprf_pkg::SEL_KEY_SCAN: begin
               st_nxt.scan_latch = port_wdata[SCAN_WIDTH-1:0];
            end
            kprf_pkg::SEL_CARRIER_CTRL: begin
               st_nxt.ctrl0 = port_wdata & kprf_pkg::CARRIER_CTRL_MASK;
            end
            kprf_pkg::SEL_PIN_MODE: begin
               st_nxt.ctrl1 = port_wdata & kprf_pkg::PIN_MODE_MASK;
            end
            default: begin
               st_nxt.scan_latch = st_r.scan_latch;
            end
         endcase
      end

      // Status test: flag follows the selected condition
      if (status_test_exec) begin
         st_nxt.cond_flag = cond_now;
      end

      // Halt: release now, clear a set flag, or really go to standby
      if (halt_exec) begin
         if (cond_now) begin
            st_nxt.cond_flag = 1'b1;
         end else if (st_r.cond_flag) begin
            st_nxt.cond_flag = 1'b0;
         end else begin
            st_nxt.standby_enter = 1'b1;
         end
      end

      // Wake-up sets the flag over a status test or halt in the same cycle; a halt can still raise standby_enter
      if (standby_exit) begin
         st_nxt.cond_flag = 1'b1;
      end

      // Pin drivers follow the registers as they now stand; sense1 output level follows indicator_level_n
      st_nxt.scan_out = st_nxt.scan_latch;
      st_nxt.scan_oe = {SCAN_WIDTH{
         st_nxt.ctrl1[kprf_pkg::KEY_SCAN_DIR_BIT]}};
      st_nxt.scan_pd =
         ~st_nxt.ctrl1[kprf_pkg::KEY_SCAN_DIR_BIT];
      st_nxt.key_pd = st_nxt.ctrl1[kprf_pkg::KEY_IN_PD_BIT];
      st_nxt.s0_in_en = st_nxt.ctrl1[kprf_pkg::SENSE0_MODE_BIT];
      st_nxt.s0_pd = st_nxt.ctrl1[kprf_pkg::SENSE_PD_BIT] &
         st_nxt.ctrl1[kprf_pkg::SENSE0_MODE_BIT];
      st_nxt.s1_oe = st_nxt.ctrl1[kprf_pkg::SENSE1_MODE_BIT];
      st_nxt.s1_out = indicator_level_n;
      st_nxt.s1_pd = st_nxt.ctrl1[kprf_pkg::SENSE_PD_BIT] &
         ~st_nxt.ctrl1[kprf_pkg::SENSE1_MODE_BIT];
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // Pin drivers reset to what the reset register values imply
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
         st_r.scan_latch <=
            kprf_pkg::KEY_SCAN_RST[SCAN_WIDTH-1:0];
         st_r.ctrl0 <= kprf_pkg::CARRIER_CTRL_RST;
         st_r.ctrl1 <= kprf_pkg::PIN_MODE_RST;
         st_r.scan_out <= {SCAN_WIDTH{1'b1}};
         st_r.scan_oe <= {SCAN_WIDTH{1'b1}};
         st_r.key_pd <= 1'b1;
         st_r.s1_out <= 1'b1;
         st_r.s1_oe <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign port_rdata = st_r.rdata;
   assign port_rvalid = st_r.rvalid;
   assign cond_flag = st_r.cond_flag;
   assign standby_enter = st_r.standby_enter;
   assign carry_flag = alu_bus.carry;
   assign carrier_ctrl = st_r.ctrl0;
   assign key_scan_out = st_r.scan_out;
   assign key_scan_oe = st_r.scan_oe;
   assign key_scan_pd_en = st_r.scan_pd;
   assign key_input_pd_en = st_r.key_pd;
   assign first_sense_pd_en = st_r.s0_pd;
   assign first_sense_in_en = st_r.s0_in_en;
   assign sense_ind_out = st_r.s1_out;
   assign sense_ind_oe = st_r.s1_oe;
   assign sense_ind_pd_en = st_r.s1_pd;
endmodule : kprf_port_core

// file: kprf_pkg.sv
package kprf_pkg;
   // ---------------------------------------------------------------
   // Port register selection codes
   // ---------------------------------------------------------------
   localparam logic [2:0] SEL_KEY_SCAN = 3'h0;
   localparam logic [2:0] SEL_KEY_INPUT = 3'h1;
   localparam logic [2:0] SEL_CARRIER_CTRL = 3'h3;
   localparam logic [2:0] SEL_PIN_MODE = 3'h4;

   // ---------------------------------------------------------------
   // Reset values and writable masks
   // ---------------------------------------------------------------
   localparam logic [7:0] KEY_SCAN_RST = 8'hFF;
   localparam logic [7:0] CARRIER_CTRL_RST = 8'h03;
   localparam logic [7:0] PIN_MODE_RST = 8'h26;
   localparam logic [7:0] CARRIER_CTRL_MASK = 8'h3F;
   localparam logic [7:0] PIN_MODE_MASK = 8'h37;
   localparam logic [1:0] INPUT_CONST_ONES = 2'h3;

   // ---------------------------------------------------------------
   // Field positions of the pin mode control register
   // ---------------------------------------------------------------
   localparam int SENSE0_MODE_BIT = 0;
   localparam int KEY_SCAN_DIR_BIT = 1;
   localparam int SENSE1_MODE_BIT = 2;
   localparam int SENSE_PD_BIT = 4;
   localparam int KEY_IN_PD_BIT = 5;

   // ---------------------------------------------------------------
   // Status test operand decode
   // ---------------------------------------------------------------
   localparam logic [2:0] COND_KEY_A = 3'h0;
   localparam logic [2:0] COND_KEY_B = 3'h3;
   localparam logic [2:0] COND_KEY_C = 3'h6;
   localparam logic [2:0] COND_TIMER_ZERO = 3'h5;
   localparam int COND_SENSE_BIT = 3;

   localparam int ACC_MSB = 3;
   localparam logic [3:0] ACC_ALL_ONES = 4'hF;

   // Instructions that touch the carry flag
   typedef enum logic [3:0] {
      ALU_NONE, ALU_AND, ALU_XOR, ALU_OR, ALU_RL, ALU_RLZ,
      ALU_INC, ALU_SET_CARRY_ADD_INSTRUCTION, ALU_MOV, ALU_IN
   } kprf_alu_op_t;
endpackage : kprf_pkg

// file: kprf_alu_if.sv
`timescale 1ns/1ps
// Carries one carry-affecting instruction from core to carry unit
interface kprf_alu_if;
   logic op_valid;
   logic [3:0] acc;
   logic [3:0] opnd;
   logic carry;
   kprf_pkg::kprf_alu_op_t op;
   modport core (output op_valid, output op, output acc, output opnd,
      input carry);
   modport unit (input op_valid, input op, input acc, input opnd,
      output carry);
endinterface : kprf_alu_if

// file: kprf_pin_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; the value moves only when the
// second and third stages agree, which also rejects one-cycle glitches
module kprf_pin_sync #(
   parameter int WIDTH = 14
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } kprf_sync_t;

   kprf_sync_t st_r;
   kprf_sync_t st_nxt;

   // Shift, then accept bits whose last two stages agree
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = pin_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.lvl[i] = st_r.s3[i];
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level = st_r.lvl;
endmodule : kprf_pin_sync

// file: kprf_carry_unit.sv
`timescale 1ns/1ps
// Carry flag; instructions not in the list leave it alone
module kprf_carry_unit (
   input wire logic clock,
   input wire logic rstn,
   kprf_alu_if.unit alu
);
   typedef struct packed {
      logic carry;
   } kprf_carry_t;

   kprf_carry_t st_r;
   kprf_carry_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (alu.op_valid) begin
         case (alu.op)
            kprf_pkg::ALU_AND, kprf_pkg::ALU_XOR: begin
               st_nxt.carry = alu.acc[kprf_pkg::ACC_MSB] &
                  alu.opnd[kprf_pkg::ACC_MSB];
            end
            kprf_pkg::ALU_RL, kprf_pkg::ALU_RLZ: begin
               st_nxt.carry = alu.acc[kprf_pkg::ACC_MSB];
            end
            kprf_pkg::ALU_INC, kprf_pkg::ALU_SET_CARRY_ADD_INSTRUCTION: begin
               st_nxt.carry =
                  (alu.acc == kprf_pkg::ACC_ALL_ONES);
            end
            kprf_pkg::ALU_OR, kprf_pkg::ALU_MOV, kprf_pkg::ALU_IN: begin
               st_nxt.carry = 1'b0;
            end
            default: begin
               st_nxt.carry = st_r.carry;
            end
         endcase
      end
   end

   // Carry is undefined after reset on the real part; zero is safer
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign alu.carry = st_r.carry;
endmodule : kprf_carry_unit

// file: kprf_key_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Key switches and sense pins on the far side of the port
// ---------------------------------------------------------------
module kprf_key_model (
   input wire logic clock,
   input wire logic [7:0] scan_out,
   input wire logic [7:0] scan_oe,
   input wire logic scan_pd,
   input wire logic [7:0] scan_press,
   input wire logic key_pd,
   input wire logic [3:0] key_press,
   input wire logic s0_pd,
   input wire logic s0_press,
   input wire logic s1_out,
   input wire logic s1_oe,
   input wire logic s1_pd,
   input wire logic s1_press,
   output logic [7:0] scan_pin,
   output logic [3:0] key_pin,
   output logic s0_pin,
   output logic s1_pin
);
   // An open pin with no pull-down wanders, so a missing pull-down shows
   logic wander = 1'b0;
   always @(posedge clock) begin
      wander <= ~wander;
   end
   function automatic logic lvl(logic p, logic pd, logic w);
      return p ? 1'b1 : (pd ? 1'b0 : w);
   endfunction : lvl
   // A pressed switch pulls high; the port's own drive wins
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         scan_pin[i] = scan_oe[i] ? scan_out[i] :
            lvl(scan_press[i], scan_pd, wander);
      end
      for (int i = 0; i < 4; i++) begin
         key_pin[i] = lvl(key_press[i], key_pd, wander);
      end
      s0_pin = lvl(s0_press, s0_pd, wander);
      s1_pin = s1_oe ? s1_out : lvl(s1_press, s1_pd, ~wander);
   end
endmodule : kprf_key_model

// file: kprf_port_sva.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Flag, carry and pin-mode checks on the port core
// ---------------------------------------------------------------
module kprf_port_sva #(
   parameter int SCAN_WIDTH = 8,
   parameter int KEY_WIDTH = 4
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic port_wr,
   input wire logic [2:0] port_sel,
   input wire logic status_test_exec,
   input wire logic halt_exec,
   input wire logic [3:0] cond_operand,
   input wire logic standby_exit,
   input wire logic timer_zero,
   input wire logic cond_flag,
   input wire logic standby_enter,
   input wire logic alu_valid,
   input wire kprf_pkg::kprf_alu_op_t alu_op,
   input wire logic [3:0] alu_acc,
   input wire logic [3:0] alu_opnd,
   input wire logic carry_flag,
   input wire logic [7:0] carrier_ctrl,
   input wire logic [SCAN_WIDTH-1:0] key_scan_oe,
   input wire logic key_scan_pd_en,
   input wire logic key_input_pd_en,
   input wire logic sense_ind_oe,
   input wire logic sense_ind_pd_en
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // Timer test with no standby exit overriding it
   sequence s_tz;
      !standby_exit && cond_operand == 4'h5;
   endsequence
   sequence s_rl;
      alu_valid && (alu_op == kprf_pkg::ALU_RL ||
         alu_op == kprf_pkg::ALU_RLZ);
   endsequence
   a_status_test_instruction_true: assert property (
      status_test_exec && timer_zero ##0 s_tz |=> cond_flag)
      else $error("status test true left flag clear");
   a_status_test_instruction_false: assert property (
      status_test_exec && !timer_zero ##0 s_tz |=> !cond_flag)
      else $error("status test false left flag set");
   a_wake_sets: assert property (standby_exit |=> cond_flag)
      else $error("standby exit left flag clear");
   a_halt_ready: assert property (
      halt_exec && timer_zero ##0 s_tz |=> cond_flag && !standby_enter)
      else $error("halt with release true misbehaved");
   a_halt_clear: assert property (
      halt_exec && !timer_zero && cond_flag ##0 s_tz |=>
      !cond_flag && !standby_enter)
      else $error("halt with flag set misbehaved");
   a_enter_cause: assert property (
      standby_enter |-> $past(halt_exec) && !$past(cond_flag) ##1
      !standby_enter)
      else $error("standby entry without cause");
   a_carry_and: assert property (
      alu_valid && (alu_op == kprf_pkg::ALU_AND ||
      alu_op == kprf_pkg::ALU_XOR) |=> carry_flag ==
      ($past(alu_acc) >= 4'h8 && $past(alu_opnd) >= 4'h8))
      else $error("logic carry wrong");
   a_carry_rl: assert property (
      s_rl |=> carry_flag == ($past(alu_acc) >= 4'h8))
      else $error("rotate carry wrong");
   a_carry_inc: assert property (
      alu_valid && (alu_op == kprf_pkg::ALU_INC ||
      alu_op == kprf_pkg::ALU_SET_CARRY_ADD_INSTRUCTION) |=>
      carry_flag == ($past(alu_acc) == 4'hF))
      else $error("increment carry wrong");
   a_carry_clr: assert property (
      alu_valid && (alu_op == kprf_pkg::ALU_OR ||
      alu_op == kprf_pkg::ALU_MOV || alu_op == kprf_pkg::ALU_IN) |=>
      !carry_flag)
      else $error("carry not cleared");
   a_scan_pd: assert property (
      key_scan_pd_en |-> key_scan_oe == '0)
      else $error("scan pull-down while driving");
   a_sense_pd: assert property (
      sense_ind_pd_en |-> !sense_ind_oe)
      else $error("sense pull-down while driving");
   a_ro_write: assert property (
      port_wr && port_sel == kprf_pkg::SEL_KEY_INPUT |=>
      $stable(carrier_ctrl) && $stable(key_input_pd_en))
      else $error("input port write changed state");
endmodule : kprf_port_sva

bind kprf_port_core kprf_port_sva #(.SCAN_WIDTH(SCAN_WIDTH),
   .KEY_WIDTH(KEY_WIDTH)) chk_i (.clock, .rstn, .port_wr, .port_sel,
   .status_test_exec, .halt_exec, .cond_operand, .standby_exit, .timer_zero,
   .cond_flag, .standby_enter, .alu_valid, .alu_op, .alu_acc, .alu_opnd,
   .carry_flag, .carrier_ctrl, .key_scan_oe, .key_scan_pd_en,
   .key_input_pd_en, .sense_ind_oe, .sense_ind_pd_en);

// file: tb_key_port_registers_and_flags.sv
`timescale 1ns/1ps
module tb_key_port_registers_and_flags;
   logic clock = 1'b0, rstn = 1'b0, port_wr = 1'b0, port_rd = 1'b0;
   logic [2:0] port_sel = 3'h0;
   logic [7:0] port_wdata = 8'h00, port_rdata, key_scan_in, key_scan_out;
   logic [7:0] key_scan_oe, carrier_ctrl, scan_press = 8'h00;
   logic port_rvalid, cond_flag, standby_enter, carry_flag, key_scan_pd_en;
   logic status_test_exec = 1'b0, halt_exec = 1'b0, standby_exit = 1'b0;
   logic timer_zero = 1'b0, alu_valid = 1'b0, indicator_level_n = 1'b1;
   logic [3:0] cond_operand = 4'h0, alu_acc = 4'h0, alu_opnd = 4'h0;
   logic [3:0] key_input_pins, key_press = 4'h0;
   kprf_pkg::kprf_alu_op_t alu_op = kprf_pkg::ALU_NONE;
   logic key_input_pd_en, first_sense_pin, first_sense_pd_en;
   logic first_sense_in_en, sense_ind_in, sense_ind_out, sense_ind_oe;
   logic sense_ind_pd_en, s0_press = 1'b0, s1_press = 1'b0;
   int mismatches = 0, check_count = 0;
   // ---------------------------------------------------------------
   // Clock, design and far-side model
   // ---------------------------------------------------------------
   always #12.5 clock = ~clock;
   kprf_port_core uut (.clock, .rstn, .port_wr, .port_rd, .port_sel,
      .port_wdata, .port_rdata, .port_rvalid, .status_test_exec,
      .halt_exec, .cond_operand, .standby_exit, .timer_zero, .cond_flag,
      .standby_enter, .alu_valid, .alu_op, .alu_acc, .alu_opnd, .carry_flag,
      .carrier_ctrl, .key_scan_in, .key_scan_out, .key_scan_oe,
      .key_scan_pd_en, .key_input_pins, .key_input_pd_en, .first_sense_pin,
      .first_sense_pd_en, .first_sense_in_en, .sense_ind_in,
      .indicator_level_n, .sense_ind_out, .sense_ind_oe, .sense_ind_pd_en);
   kprf_key_model km (.clock, .scan_out(key_scan_out), .scan_oe(key_scan_oe),
      .scan_pd(key_scan_pd_en), .scan_press, .key_pd(key_input_pd_en),
      .key_press, .s0_pd(first_sense_pd_en), .s0_press,
      .s1_out(sense_ind_out), .s1_oe(sense_ind_oe), .s1_pd(sense_ind_pd_en),
      .s1_press, .scan_pin(key_scan_in), .key_pin(key_input_pins),
      .s0_pin(first_sense_pin), .s1_pin(sense_ind_in));
   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   task automatic close_out;
      $display("Checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [2:0] sel, input logic [7:0] d);
      @(negedge clock);
      port_wr = 1'b1;
      port_sel = sel;
      port_wdata = d;
      @(negedge clock);
      port_wr = 1'b0;
   endtask : wr
   // Read answer stands one cycle; poll it under a small bound
   task automatic rchk(input string nm, input logic [2:0] sel, logic [7:0] e);
      int n;
      @(negedge clock);
      port_rd = 1'b1;
      port_sel = sel;
      @(negedge clock);
      port_rd = 1'b0;
      for (n = 0; n < 4 && port_rvalid !== 1'b1; n++) @(negedge clock);
      chk(nm, e, port_rdata);
      if (n == 4) begin
         mismatches++;
         $display("CHECK FAILED %s expected answer seen none", nm);
         close_out();
      end
   endtask : rchk
   task automatic ins(logic st, logic hl, logic [3:0] op, logic tz,
      logic ef, logic ee);
      @(negedge clock);
      status_test_exec = st;
      halt_exec = hl;
      cond_operand = op;
      timer_zero = tz;
      @(negedge clock);
      status_test_exec = 1'b0;
      halt_exec = 1'b0;
      chk("cond_flag", {7'h0, ef}, {7'h0, cond_flag});
      chk("standby_enter", {7'h0, ee}, {7'h0, standby_enter});
   endtask : ins
   task automatic alu(kprf_pkg::kprf_alu_op_t op, logic [3:0] a, logic [3:0] b,
      logic e);
      @(negedge clock);
      alu_valid = 1'b1;
      alu_op = op;
      alu_acc = a;
      alu_opnd = b;
      @(negedge clock);
      alu_valid = 1'b0;
      chk("carry_flag", {7'h0, e}, {7'h0, carry_flag});
   endtask : alu
   // Pins need four stable edges before reads see them
   task automatic settle;
      repeat (6) @(negedge clock);
   endtask : settle
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (16) @(negedge clock);
      rstn = 1'b1;
      settle();
      rchk("ctrl1", 3'h4, 8'h26);
      rchk("ctrl0", 3'h3, 8'h03);
      rchk("scan", 3'h0, 8'hFF);
      rchk("input", 3'h1, 8'h0F);
      rchk("unused", 3'h2, 8'h00);
      chk("scan_oe", 8'hFF, key_scan_oe);
      chk("scan_pd", 8'h00, {7'h0, key_scan_pd_en});
      chk("key_pd", 8'h01, {7'h0, key_input_pd_en});
      wr(3'h3, 8'hFF);
      rchk("ctrl0", 3'h3, 8'h3F);
      chk("carrier_ctrl", 8'h3F, carrier_ctrl);
      wr(3'h4, 8'hFF);
      rchk("ctrl1", 3'h4, 8'h37);
      // Scan port in input direction reads pins, latch still written
      wr(3'h4, 8'h35);
      chk("scan_oe", 8'h00, key_scan_oe);
      chk("scan_pd", 8'h01, {7'h0, key_scan_pd_en});
      wr(3'h0, 8'hA5);
      scan_press = 8'h3C;
      settle();
      rchk("scan pins", 3'h0, 8'h3C);
      wr(3'h4, 8'h37);
      rchk("scan latch", 3'h0, 8'hA5);
      chk("scan_out", 8'hA5, key_scan_out);
      scan_press = 8'h00;
      // Input port with sense pins in input mode
      wr(3'h4, 8'h31);
      key_press = 4'h9;
      s1_press = 1'b1;
      settle();
      rchk("input", 3'h1, 8'h9B);
      chk("s0_pd", 8'h01, {7'h0, first_sense_pd_en});
      chk("s1_pd", 8'h01, {7'h0, sense_ind_pd_en});
      chk("s1_oe", 8'h00, {7'h0, sense_ind_oe});
      wr(3'h1, 8'h00);
      rchk("input", 3'h1, 8'h9B);
      rchk("ctrl1", 3'h4, 8'h31);
      wr(3'h4, 8'h30);
      settle();
      rchk("s0 off", 3'h1, 8'h9F);
      chk("s0_in", 8'h00, {7'h0, first_sense_in_en});
      wr(3'h4, 8'h11);
      chk("key_pd", 8'h00, {7'h0, key_input_pd_en});
      wr(3'h4, 8'h31);
      s1_press = 1'b0;
      // Condition flag: key codes, timer, halt, wake, sense
      foreach (cond_operand[i]) begin
         if (i != 3) begin
            key_press = 4'h4;
            settle();
            ins(1'b1, 1'b0, 4'(i * 3), 1'b0, 1'b1, 1'b0);
            key_press = 4'h0;
            settle();
            ins(1'b1, 1'b0, 4'(i * 3), 1'b0, 1'b0, 1'b0);
         end
      end
      ins(1'b1, 1'b0, 4'h5, 1'b1, 1'b1, 1'b0);
      ins(1'b1, 1'b0, 4'h5, 1'b0, 1'b0, 1'b0);
      ins(1'b0, 1'b1, 4'h5, 1'b1, 1'b1, 1'b0);
      ins(1'b0, 1'b1, 4'h5, 1'b0, 1'b0, 1'b0);
      ins(1'b0, 1'b1, 4'h5, 1'b0, 1'b0, 1'b1);
      @(negedge clock);
      standby_exit = 1'b1;
      @(negedge clock);
      standby_exit = 1'b0;
      chk("cond_flag", 8'h01, {7'h0, cond_flag});
      s1_press = 1'b1;
      settle();
      ins(1'b1, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0);
      ins(1'b1, 1'b0, 4'h8, 1'b0, 1'b1, 1'b0);
      // Indicator driven low: the pin, and bit 3 read back, follow it
      wr(3'h4, 8'h35);
      indicator_level_n = 1'b0;
      settle();
      chk("s1_oe", 8'h01, {7'h0, sense_ind_oe});
      chk("s1_out", 8'h00, {7'h0, sense_ind_out});
      rchk("s1 out", 3'h1, 8'h03);
      // Carry: each clearing case follows a setting one
      alu(kprf_pkg::ALU_AND, 4'h8, 4'h8, 1'b1);
      alu(kprf_pkg::ALU_OR, 4'hF, 4'hF, 1'b0);
      alu(kprf_pkg::ALU_XOR, 4'hF, 4'hF, 1'b1);
      alu(kprf_pkg::ALU_MOV, 4'hF, 4'h0, 1'b0);
      alu(kprf_pkg::ALU_RL, 4'h9, 4'h0, 1'b1);
      alu(kprf_pkg::ALU_IN, 4'hF, 4'h0, 1'b0);
      alu(kprf_pkg::ALU_RLZ, 4'hF, 4'h0, 1'b1);
      alu(kprf_pkg::ALU_AND, 4'h8, 4'h7, 1'b0);
      alu(kprf_pkg::ALU_INC, 4'hF, 4'h0, 1'b1);
      alu(kprf_pkg::ALU_XOR, 4'h7, 4'h8, 1'b0);
      alu(kprf_pkg::ALU_SET_CARRY_ADD_INSTRUCTION, 4'hF, 4'h0, 1'b1);
      alu(kprf_pkg::ALU_RLZ, 4'h7, 4'h0, 1'b0);
      alu(kprf_pkg::ALU_INC, 4'hF, 4'h0, 1'b1);
      alu(kprf_pkg::ALU_SET_CARRY_ADD_INSTRUCTION, 4'hE, 4'h0, 1'b0);
      close_out();
   end
endmodule : tb_key_port_registers_and_flags
